// ---- capture_compare_params.svh ----
// Constants for the capture/compare and watchdog block
`ifndef CAPTURE_COMPARE_PARAMS_SVH
`define CAPTURE_COMPARE_PARAMS_SVH

`define NUM_MODULES 3
`define WD_MODULE 2
// Mode register bit positions and watchdog forced mode
`define MB_WIDE 7
`define MB_CMP_EN 6
`define MB_RISE 5
`define MB_FALL 4
`define MB_HIT 3
`define MB_FLIP 2
`define MB_MOD 1
`define MB_IRQ 0
`define WD_FORCED_MODE 8'h48
// Control register bit positions
`define CB_RUN 0
`define CB_IDLE 1
`define CB_SEL_LSB 2
`define CB_SEL_MSB 4
`define CB_WD 8
`define CB_GIE 9
`define CB_CAIE 10
// Register byte addresses
`define A_CTRL 8'h00
`define A_FLAGS 8'h04
`define A_CNT_LO 8'h08
`define A_CNT_HI 8'h0c
`define MOD_BASE 8'h10
`define MOD_STRIDE 8'h10
`define OFS_MODE 8'h00
`define OFS_CMP_LO 8'h04
`define OFS_CMP_HI 8'h08
// Reset value and prescaler limit
`define WD_EN_RST 1'b0
`define PRESC_MAX 7'h7f
// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ---- capture_compare_pkg.sv ----
// Types and mode decoding for the capture/compare block
`include "capture_compare_params.svh"

package capture_compare_pkg;

	typedef enum logic [2:0] {
		MODE_OFF, MODE_CAPTURE, MODE_TIMER, MODE_HSO, MODE_FREQ,
		MODE_PWM8, MODE_PWM_WIDE
	} cc_mode_e;

	typedef struct packed {
		logic pin_prev;
		logic out;
	} unit_state_s;

	typedef struct packed {
		logic run_sw;
		logic idle_sus;
		logic [2:0] clk_sel;
		logic wd_en;
		logic gie;
		logic caie;
		logic [`NUM_MODULES-1:0] flags;
		logic [15:0] counter;
		logic [6:0] presc;
		logic [`NUM_MODULES-1:0][7:0] mode;
		logic [`NUM_MODULES-1:0][15:0] cmp;
		logic [`NUM_MODULES-1:0] sync1;
		logic [`NUM_MODULES-1:0] sync2;
		logic [`NUM_MODULES-1:0] io_out;
		logic [`NUM_MODULES-1:0] io_oe_n;
		logic irq;
		logic wd_rst;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} top_state_s;

	function automatic cc_mode_e mode_decode(input logic [7:0] m);
		logic cap;
		cap = m[`MB_RISE] | m[`MB_FALL];
		if (cap && !m[`MB_HIT] && !m[`MB_FLIP] && !m[`MB_MOD]) begin
			mode_decode = MODE_CAPTURE;
		end else if (!m[`MB_CMP_EN] || cap) begin
			mode_decode = MODE_OFF;
		end else if (m[`MB_MOD]) begin
			if (m[`MB_FLIP]) begin
				mode_decode = MODE_FREQ;
			end else begin
				mode_decode = m[`MB_WIDE] ? MODE_PWM_WIDE : MODE_PWM8;
			end
		end else if (m[`MB_HIT]) begin
			mode_decode = m[`MB_FLIP] ? MODE_HSO : MODE_TIMER;
		end else begin
			mode_decode = MODE_OFF;
		end
	endfunction : mode_decode

endpackage : capture_compare_pkg

// ---- cc_link.sv ----
// Link between the register core and one capture/compare unit
`timescale 1ns/100ps

interface cc_link;
	logic [15:0] counter;
	logic tick;
	logic [7:0] mode;
	logic [15:0] cmp;
	logic pin_in;
	logic capture_evt;
	logic match_evt;
	logic pin_out;
	logic drive;

	modport ctrl (
		output counter, tick, mode, cmp, pin_in,
		input capture_evt, match_evt, pin_out, drive
	);
	modport unit (
		input counter, tick, mode, cmp, pin_in,
		output capture_evt, match_evt, pin_out, drive
	);
endinterface : cc_link

// ---- capture_compare_unit.sv ----
// One capture/compare module: edge capture, compare match and outputs
`timescale 1ns/100ps
`include "capture_compare_params.svh"

module capture_compare_unit
	import capture_compare_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	cc_link.unit lk
);

	unit_state_s s_reg;
	unit_state_s s_next;
	cc_mode_e mode;
	logic rise;
	logic fall;
	logic full_hit;
	logic lo_hit;

	// =============================================================
	// Decode and compare
	assign mode = mode_decode(lk.mode);
	assign rise = lk.pin_in & ~s_reg.pin_prev;
	assign fall = ~lk.pin_in & s_reg.pin_prev;
	assign full_hit = lk.counter == lk.cmp;
	assign lo_hit = lk.counter[7:0] == lk.cmp[7:0];

	// Either enabled edge captures, so both bits give any transition
	assign lk.capture_evt = (mode == MODE_CAPTURE) &&
		((lk.mode[`MB_RISE] && rise) ||
		(lk.mode[`MB_FALL] && fall));
	// Matched only on a tick, so a counter held between prescaler ticks flags once
	assign lk.match_evt = lk.tick && full_hit && lk.mode[`MB_HIT] &&
		(mode == MODE_TIMER || mode == MODE_HSO);
	assign lk.pin_out = s_reg.out;
	assign lk.drive = (mode == MODE_HSO) || (mode == MODE_FREQ) ||
		(mode == MODE_PWM8) || (mode == MODE_PWM_WIDE);

	// =============================================================
	// State
	always_comb begin
		s_next = s_reg;
		s_next.pin_prev = lk.pin_in;
		unique case (mode)
			MODE_HSO: begin
				if (lk.tick && full_hit) begin
					s_next.out = ~s_reg.out;
				end
			end
			MODE_FREQ: begin
				if (lk.tick && lo_hit) begin
					s_next.out = ~s_reg.out;
				end
			end
			MODE_PWM8: begin
				s_next.out = lk.counter[7:0] >= lk.cmp[7:0];
			end
			MODE_PWM_WIDE: begin
				s_next.out = lk.counter >= lk.cmp;
			end
			MODE_OFF, MODE_CAPTURE, MODE_TIMER: begin
				s_next.out = s_reg.out;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule : capture_compare_unit

// ---- capture_compare_watchdog.sv ----
// Counter array with capture/compare modules, watchdog and register slave
//
// Contract
// - Each module runs on its own in one of six modes from its mode register.
// - Rising capture bit alone captures on a rising pin edge.
// - Falling capture bit alone captures on a falling pin edge.
// - Both capture bits set capture on any pin transition.
// - Comparator plus compare-hit enable, with no capture, flip or mod bit, selects software timer.
// - Comparator enabled: decode high-speed, frequency, 8-bit or 16-bit PWM.
// - A module's interrupt enable gates its flag onto the interrupt request.
// - Module interrupts need both global and counter-array interrupt enables.
// - Software timer: counter equal to compare sets the flag, may interrupt.
// - Writing compare low byte clears that module's comparator enable.
// - Writing compare high byte sets that module's comparator enable.
// - Watchdog on: counter runs unless idle-suspended, counter byte writes ignored.
// - Watchdog on: clock source and idle suspend bits frozen.
// - Watchdog on: module 2 forced to timer, its mode writes ignored.
// - Watchdog on: run bit writes do not stop the running counter.
// - Run bit reads what software set, zero if never set.
// - Module 2 compare high write loads counter high plus low offset.
// - Module 2 compare high byte is compared with counter high byte.
// - Watchdog reset when low byte overflows with high bytes matching.
// - Watchdog on: writing 1 to module 2 flag forces a watchdog reset.
// - Timeout is 256 times offset plus 256 minus low byte, in ticks.
`timescale 1ns/100ps
`include "capture_compare_params.svh"

module capture_compare_watchdog
	import capture_compare_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic idle_i,
	input wire logic [`NUM_MODULES-1:0] module_io_i,
	output logic [`NUM_MODULES-1:0] module_io_o,
	output logic [`NUM_MODULES-1:0] module_io_oe_n_o,
	output logic irq_o,
	output logic watchdog_reset_o,
	input wire logic [31:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	top_state_s q;
	top_state_s n;
	logic tick;
	logic counting;
	logic [`NUM_MODULES-1:0] cap_evt;
	logic [`NUM_MODULES-1:0] match_evt;
	logic [`NUM_MODULES-1:0] pin_out;
	logic [`NUM_MODULES-1:0] drive;

	// =============================================================
	// Helpers
	function automatic logic [7:0] mod_addr(input int idx,
		input logic [7:0] ofs);
		mod_addr = 8'(`MOD_BASE + idx * `MOD_STRIDE + ofs);
	endfunction : mod_addr

	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		lane_merge = (old & ~m) | (wd & m);
	endfunction : lane_merge

	// Prescale mask: source code k gives one tick per 2**k clocks
	function automatic logic [6:0] div_mask(input logic [2:0] k);
		div_mask = `PRESC_MAX >> (3'h7 - k);
	endfunction : div_mask

	function automatic logic [31:0] ctrl_word(input top_state_s s);
		ctrl_word = '0;
		ctrl_word[`CB_RUN] = s.run_sw;
		ctrl_word[`CB_IDLE] = s.idle_sus;
		ctrl_word[`CB_SEL_MSB:`CB_SEL_LSB] = s.clk_sel;
		ctrl_word[`CB_WD] = s.wd_en;
		ctrl_word[`CB_GIE] = s.gie;
		ctrl_word[`CB_CAIE] = s.caie;
	endfunction : ctrl_word

	// Returns {hit, data}; hit low marks an unmapped address
	function automatic logic [32:0] reg_read(input top_state_s s,
		input logic [7:0] a);
		reg_read = '0;
		if (a == `A_CTRL) begin
			reg_read = {1'b1, ctrl_word(s)};
		end else if (a == `A_FLAGS) begin
			reg_read = {1'b1, 29'h0, s.flags};
		end else if (a == `A_CNT_LO) begin
			reg_read = {1'b1, 24'h0, s.counter[7:0]};
		end else if (a == `A_CNT_HI) begin
			reg_read = {1'b1, 24'h0, s.counter[15:8]};
		end
		for (int i = 0; i < `NUM_MODULES; i++) begin
			if (a == mod_addr(i, `OFS_MODE)) begin
				reg_read = {1'b1, 24'h0, s.mode[i]};
			end
			if (a == mod_addr(i, `OFS_CMP_LO)) begin
				reg_read = {1'b1, 24'h0, s.cmp[i][7:0]};
			end
			if (a == mod_addr(i, `OFS_CMP_HI)) begin
				reg_read = {1'b1, 24'h0, s.cmp[i][15:8]};
			end
		end
	endfunction : reg_read

	// =============================================================
	// Counter clocking
	// Watchdog holds the counter running whatever the run bit says; idle suspend still pauses it
	assign counting = (q.run_sw | q.wd_en) &&
		!(idle_i && q.idle_sus);
	assign tick = counting && (q.presc == div_mask(q.clk_sel));

	// =============================================================
	// Module units
	for (genvar g = 0; g < `NUM_MODULES; g++) begin : g_mod
		cc_link lk ();
		assign lk.counter = q.counter;
		assign lk.tick = tick;
		// Module 2 is pinned to timer while the watchdog owns it
		assign lk.mode = (g == `WD_MODULE && q.wd_en) ?
			`WD_FORCED_MODE : q.mode[g];
		assign lk.cmp = q.cmp[g];
		assign lk.pin_in = q.sync2[g];
		assign cap_evt[g] = lk.capture_evt;
		assign match_evt[g] = lk.match_evt;
		assign pin_out[g] = lk.pin_out;
		assign drive[g] = lk.drive;

		capture_compare_unit u_unit (
			.clk_i(clk_i),
			.rst_n_i(rst_n_i),
			.lk(lk.unit)
		);
	end

	// =============================================================
	// Next state
	always_comb begin
		logic [7:0] wa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [31:0] cw;
		logic hit;
		logic [32:0] rd;
		logic irq_any;
		wa = q.aw_addr;
		wd = q.w_data;
		ws = q.w_strb;
		cw = '0;
		hit = 1'b0;
		rd = '0;
		irq_any = 1'b0;
		n = q;
		n.wd_rst = 1'b0;
		n.sync1 = module_io_i;
		n.sync2 = q.sync1;

		// Counter and prescaler
		if (counting) begin
			n.presc = tick ? 7'h00 : q.presc + 7'h01;
		end
		if (tick) begin
			n.counter = q.counter + 16'h0001;
		end
		// High byte match seen at the low byte wrap
		if (tick && q.wd_en && q.counter[7:0] == 8'hff &&
			q.cmp[`WD_MODULE][15:8] == q.counter[15:8]) begin
			n.wd_rst = 1'b1;
		end

		// Write address and data are taken in either order
		if (s_axi_awvalid_i && q.awready) begin
			n.aw_full = 1'b1;
			n.aw_addr = s_axi_awaddr_i[7:0];
		end
		if (s_axi_wvalid_i && q.wready) begin
			n.w_full = 1'b1;
			n.w_data = s_axi_wdata_i;
			n.w_strb = s_axi_wstrb_i;
		end
		if (q.bvalid && s_axi_bready_i) begin
			n.bvalid = 1'b0;
		end

		if (q.aw_full && q.w_full) begin
			n.aw_full = 1'b0;
			n.w_full = 1'b0;
			n.bvalid = 1'b1;
			if (wa == `A_CTRL) begin
				hit = 1'b1;
				cw = lane_merge(ctrl_word(q), wd, ws);
				n.run_sw = cw[`CB_RUN];
				n.wd_en = cw[`CB_WD];
				n.gie = cw[`CB_GIE];
				n.caie = cw[`CB_CAIE];
				if (!q.wd_en) begin
					n.idle_sus = cw[`CB_IDLE];
					n.clk_sel = cw[`CB_SEL_MSB:`CB_SEL_LSB];
				end
			end
			if (wa == `A_FLAGS) begin
				hit = 1'b1;
				if (ws[0]) begin
					n.flags = wd[`NUM_MODULES-1:0];
					if (q.wd_en && wd[`WD_MODULE]) begin
						n.wd_rst = 1'b1;
					end
				end
			end
			if (wa == `A_CNT_LO) begin
				hit = 1'b1;
				if (ws[0] && !q.wd_en) begin
					n.counter[7:0] = wd[7:0];
				end
			end
			if (wa == `A_CNT_HI) begin
				hit = 1'b1;
				if (ws[0] && !q.wd_en) begin
					n.counter[15:8] = wd[7:0];
				end
			end
			for (int i = 0; i < `NUM_MODULES; i++) begin
				if (wa == mod_addr(i, `OFS_MODE)) begin
					hit = 1'b1;
					if (ws[0] && !(i == `WD_MODULE && q.wd_en)) begin
						n.mode[i] = wd[7:0];
					end
				end
				if (wa == mod_addr(i, `OFS_CMP_LO)) begin
					hit = 1'b1;
					if (ws[0]) begin
						n.cmp[i][7:0] = wd[7:0];
						n.mode[i][`MB_CMP_EN] = 1'b0;
					end
				end
				if (wa == mod_addr(i, `OFS_CMP_HI)) begin
					hit = 1'b1;
					if (ws[0]) begin
						n.mode[i][`MB_CMP_EN] = 1'b1;
						if (i == `WD_MODULE) begin
							// Any value written only refreshes the deadline
							n.cmp[i][15:8] = q.counter[15:8] +
								q.cmp[i][7:0];
						end else begin
							n.cmp[i][15:8] = wd[7:0];
						end
					end
				end
			end
			n.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		n.awready = !n.aw_full && !n.bvalid;
		n.wready = !n.w_full && !n.bvalid;

		// Read channel
		if (q.rvalid && s_axi_rready_i) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && q.arready) begin
			rd = reg_read(q, s_axi_araddr_i[7:0]);
			n.rvalid = 1'b1;
			n.rdata = rd[31:0];
			n.rresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
		end
		n.arready = !n.rvalid;

		// Hardware events last, so a set beats a same-cycle clear
		for (int i = 0; i < `NUM_MODULES; i++) begin
			if (cap_evt[i]) begin
				n.cmp[i] = q.counter;
				n.flags[i] = 1'b1;
			end
			if (match_evt[i]) begin
				n.flags[i] = 1'b1;
			end
			irq_any = irq_any | (n.flags[i] & n.mode[i][`MB_IRQ]);
			n.io_out[i] = pin_out[i];
			n.io_oe_n[i] = ~drive[i];
		end
		n.irq = irq_any && n.gie && n.caie;
	end

	// =============================================================
	// Registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
			q.wd_en <= `WD_EN_RST;
			q.io_oe_n <= '1;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// =============================================================
	// Outputs
	assign module_io_o = q.io_out;
	assign module_io_oe_n_o = q.io_oe_n;
	assign irq_o = q.irq;
	assign watchdog_reset_o = q.wd_rst;
	assign s_axi_awready_o = q.awready;
	assign s_axi_wready_o = q.wready;
	assign s_axi_bresp_o = q.bresp;
	assign s_axi_bvalid_o = q.bvalid;
	assign s_axi_arready_o = q.arready;
	assign s_axi_rdata_o = q.rdata;
	assign s_axi_rresp_o = q.rresp;
	assign s_axi_rvalid_o = q.rvalid;

endmodule : capture_compare_watchdog

// ---- capture_compare_watchdog_sva.sv ----
// Concurrent checks on the register bus and watchdog output
`timescale 1ns/100ps
`include "capture_compare_params.svh"

module capture_compare_watchdog_sva (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [1:0] s_axi_bresp_o,
	input wire logic [31:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic watchdog_reset_o
);
	// ====
	// Bus handshakes and pulse shape
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_BVALID_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped early");
	AST_RVALID_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped early");
	AST_READ_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o)
		else $error("read answer late");
	AST_WRITE_LAT: assert property (s_axi_awvalid_i && s_axi_awready_o &&
		s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
		else $error("write answer late");
	AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read accepted while answer pending");
	AST_AW_BLOCK: assert property (s_axi_bvalid_o
		|-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted while answer pending");
	AST_UNMAPPED_READ: assert property (s_axi_arvalid_i && s_axi_arready_o
		&& s_axi_araddr_i[7:0] == 8'hfc
		|=> s_axi_rdata_o == 32'h0 && s_axi_rresp_o == `RESP_SLVERR)
		else $error("unmapped read not refused");
	AST_WD_PULSE: assert property (watchdog_reset_o |=> !watchdog_reset_o)
		else $error("watchdog reset longer than one cycle");
endmodule : capture_compare_watchdog_sva

bind capture_compare_watchdog capture_compare_watchdog_sva chk_u (.*);

// ---- pin_model.sv ----
// Far side of the module pins
`timescale 1ns/100ps
`include "capture_compare_params.svh"

module pin_model (
	input wire logic [`NUM_MODULES-1:0] level_i,
	input wire logic [`NUM_MODULES-1:0] drive_i,
	input wire logic [`NUM_MODULES-1:0] oe_n_i,
	output logic [`NUM_MODULES-1:0] pin_o
);
	// ====
	// Pin level: device wins while it drives
	assign pin_o = (~oe_n_i & drive_i) | (oe_n_i & level_i);
endmodule : pin_model

// ---- capture_compare_watchdog_test.sv ----
// Self-checking bench for the capture/compare and watchdog block
`timescale 1ns/100ps
`include "capture_compare_params.svh"

module capture_compare_watchdog_test;
	logic clk_i, rst_n_i, idle_i, rready, bready, awvalid, wvalid, arvalid;
	logic [2:0] lvl, pin, io_o, oe_n;
	logic irq_o, wd_o, awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr;
	logic [15:0] c, t;
	logic [7:0] d;
	int n_fail, comparisons, i, cyc, n_wd, t_wd, t0;
	logic [7:0] mt[7] = '{8'h48, 8'h4c, 8'h46, 8'h42, 8'hc2, 8'h20, 8'h02};
	logic oe_x[7] = '{1, 0, 0, 0, 0, 1, 1};
	// Counter and compare both zero, so PWM drives high and later modes hold
	logic io_x[7] = '{0, 0, 0, 1, 1, 1, 1};
	logic [7:0] cm[3] = '{8'h20, 8'h10, 8'h30};

	capture_compare_watchdog dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.idle_i(idle_i), .module_io_i(pin), .module_io_o(io_o),
		.module_io_oe_n_o(oe_n), .irq_o(irq_o), .watchdog_reset_o(wd_o),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready));
	pin_model pin_u (.level_i(lvl), .drive_i(io_o), .oe_n_i(oe_n),
		.pin_o(pin));

	// ====
	// Clock and pulse monitor
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Pulse may land inside a bus task, so count it here
	always @(posedge clk_i) begin
		cyc++;
		if (wd_o === 1'b1) begin
			n_wd++;
			t_wd = cyc;
		end
	end

	// ====
	// Helpers
	function automatic logic [7:0] ma(input int n, input logic [7:0] o);
		return 8'(`MOD_BASE + `MOD_STRIDE * n + o);
	endfunction : ma
	function automatic logic hit(input logic [7:0] m, input logic rise);
		return rise ? m[`MB_RISE] : m[`MB_FALL];
	endfunction : hit
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
		comparisons++;
		if (seen !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
		@(posedge clk_i);
		awaddr <= {24'h0, a};
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (awvalid || wvalid);
		repeat ($urandom_range(2)) @(posedge clk_i);
		bready <= 1'b1;
		do @(posedge clk_i); while (bvalid !== 1'b1);
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_i);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		repeat ($urandom_range(2)) @(posedge clk_i);
		rready <= 1'b1;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask : rd
	task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a);
		chk("rdata", rv, e);
		chk("rresp", {30'h0, rr}, {30'h0, er});
	endtask : rchk
	task conclude;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	initial begin
		#1000000;
		n_fail++;
		conclude();
	end

	// ====
	// Main sequence
	initial begin
		{rst_n_i, idle_i, rready, bready, awvalid, wvalid, arvalid} = '0;
		{lvl, awaddr, wdata, araddr} = '0;
		wstrb = 4'hf;
		void'($urandom(43));
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rchk(`A_CTRL, 32'h0, `RESP_OKAY);
		rchk(8'hfc, 32'h0, `RESP_SLVERR);
		wr(8'hf0, 32'h1, `RESP_SLVERR);
		wr(ma(0, `OFS_MODE), 32'h48, `RESP_OKAY);
		wr(ma(0, `OFS_CMP_LO), 32'h0, `RESP_OKAY);
		rchk(ma(0, `OFS_MODE), 32'h08, `RESP_OKAY);
		wr(ma(0, `OFS_CMP_HI), 32'h0, `RESP_OKAY);
		rchk(ma(0, `OFS_MODE), 32'h48, `RESP_OKAY);
		foreach (mt[k]) begin
			wr(ma(0, `OFS_MODE), {24'h0, mt[k]}, `RESP_OKAY);
			repeat (3) @(posedge clk_i);
			chk("oe_n", {31'h0, oe_n[0]}, {31'h0, oe_x[k]});
			chk("io", {31'h0, io_o[0]}, {31'h0, io_x[k]});
		end
		// Counter stopped, so the captured value is exact
		c = 16'($urandom);
		wr(`A_CNT_LO, {24'h0, c[7:0]}, `RESP_OKAY);
		wr(`A_CNT_HI, {24'h0, c[15:8]}, `RESP_OKAY);
		foreach (cm[k]) begin
			wr(ma(1, `OFS_MODE), {24'h0, cm[k]}, `RESP_OKAY);
			wr(`A_FLAGS, 32'h0, `RESP_OKAY);
			lvl[1] <= 1'b1;
			repeat (8) @(posedge clk_i);
			rchk(`A_FLAGS, {30'h0, hit(cm[k], 1), 1'b0}, `RESP_OKAY);
			wr(`A_FLAGS, 32'h0, `RESP_OKAY);
			lvl[1] <= 1'b0;
			repeat (8) @(posedge clk_i);
			rchk(`A_FLAGS, {30'h0, hit(cm[k], 0), 1'b0}, `RESP_OKAY);
		end
		rchk(ma(1, `OFS_CMP_LO), {24'h0, c[7:0]}, `RESP_OKAY);
		rchk(ma(1, `OFS_CMP_HI), {24'h0, c[15:8]}, `RESP_OKAY);
		wr(`A_FLAGS, 32'h0, `RESP_OKAY);
		d = 8'($urandom_range(200, 20));
		t = c + 16'(d);
		wr(ma(0, `OFS_MODE), 32'h49, `RESP_OKAY);
		wr(ma(0, `OFS_CMP_LO), {24'h0, t[7:0]}, `RESP_OKAY);
		wr(ma(0, `OFS_CMP_HI), {24'h0, t[15:8]}, `RESP_OKAY);
		wr(`A_CTRL, 32'h601, `RESP_OKAY);
		for (i = 0; i < 300 && irq_o !== 1'b1; i++) @(posedge clk_i);
		chk("irq", {31'h0, irq_o}, 32'h1);
		rchk(`A_FLAGS, 32'h1, `RESP_OKAY);
		wr(ma(0, `OFS_MODE), 32'h48, `RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk("irq", {31'h0, irq_o}, 32'h0);
		wr(ma(0, `OFS_MODE), 32'h49, `RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk("irq", {31'h0, irq_o}, 32'h1);
		wr(`A_CTRL, 32'h201, `RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk("irq", {31'h0, irq_o}, 32'h0);
		rchk(`A_FLAGS, 32'h1, `RESP_OKAY);
		wr(`A_FLAGS, 32'h0, `RESP_OKAY);
		rchk(`A_FLAGS, 32'h0, `RESP_OKAY);
		wr(`A_CTRL, 32'h0, `RESP_OKAY);
		wr(`A_CNT_LO, 32'h0, `RESP_OKAY);
		wr(`A_CNT_HI, 32'h0, `RESP_OKAY);
		wr(ma(2, `OFS_CMP_LO), 32'h1, `RESP_OKAY);
		wr(ma(2, `OFS_CMP_HI), 32'h0, `RESP_OKAY);
		rchk(ma(2, `OFS_CMP_HI), 32'h1, `RESP_OKAY);
		wr(`A_CTRL, 32'h100, `RESP_OKAY);
		rchk(`A_CTRL, 32'h100, `RESP_OKAY);
		wr(`A_CTRL, 32'h11e, `RESP_OKAY);
		rchk(`A_CTRL, 32'h100, `RESP_OKAY);
		wr(ma(2, `OFS_MODE), 32'h20, `RESP_OKAY);
		rchk(ma(2, `OFS_MODE), 32'h40, `RESP_OKAY);
		wr(`A_CNT_HI, 32'h80, `RESP_OKAY);
		rd(`A_CNT_HI);
		chk("cnt_hi", {31'h0, rv[7:0] < 8'h80}, 32'h1);
		// Idle high would pause the counter if the suspend bit had moved
		idle_i <= 1'b1;
		rd(`A_CNT_LO);
		d = rv[7:0];
		rd(`A_CNT_LO);
		idle_i <= 1'b0;
		chk("cnt_run", {31'h0, rv[7:0] !== d}, 32'h1);
		wr(ma(2, `OFS_CMP_HI), 32'h0, `RESP_OKAY);
		t0 = cyc;
		i = n_wd;
		while (n_wd == i && cyc - t0 < 600) @(posedge clk_i);
		// Offset 1 gives 256 plus up to 256 counts
		chk("wd_time", {31'h0, t_wd - t0 >= 250 && t_wd - t0 <= 515}, 32'h1);
		i = n_wd;
		wr(`A_FLAGS, 32'h4, `RESP_OKAY);
		repeat (4) @(posedge clk_i);
		chk("wd_force", n_wd - i, 32'h1);
		wr(`A_CTRL, 32'h0, `RESP_OKAY);
		conclude();
	end
endmodule : capture_compare_watchdog_test
